// ===== rtl/wakeup_timer_pkg.sv
// Constants shared by the periodic wakeup timer design
package wakeup_timer_pkg;
   // Register byte addresses
   localparam logic [15:0] ADDR_CONTROL = 16'h02f2; // Control and flag
   localparam logic [15:0] ADDR_TRIM = 16'h02f3; // Period trim
   localparam logic [15:0] ADDR_RATE_HI = 16'h02f4; // Rate value, upper byte
   localparam logic [15:0] ADDR_RATE_LO = 16'h02f5; // Rate value, lower byte

   // Control register bit positions
   localparam int BIT_CLOCK_SOURCE_SELECT = 7;
   localparam int BIT_PIN_WAVEFORM_SELECT = 4;
   localparam int BIT_PIN_OUTPUT_ENABLE = 3;
   localparam int BIT_TIMER_RUN_ENABLE = 2;
   localparam int BIT_TIMEOUT_IRQ_ENABLE = 1;
   localparam int BIT_TIMEOUT_FLAG = 0;

   // Trim field placement
   localparam int TRIM_LSB = 2;
   localparam int TRIM_MSB = 7;
   localparam int TRIM_WIDTH = TRIM_MSB - TRIM_LSB + 1;
   localparam logic [5:0] TRIM_RESET = 6'h00; // Default preset of the trim field

   // Widths
   localparam int DATA_WIDTH = 8;
   localparam int RATE_WIDTH = 16;
   localparam int COUNT_WIDTH = RATE_WIDTH + 1; // Counts ticks of 2*(rate+1)
   localparam int OSC_CNT_WIDTH = 20;

   // Reset values
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] RATE_RESET = 16'h0000;

   // Timing: autonomous tick of the oscillator
   localparam real OSC_TICK_MS = 0.1; // Autonomous base tick
   localparam real MCLK_PERIOD_NS = 10.0; // 100 MHz system clock
   localparam int OSC_TICK_CYCLES = int'($ceil(OSC_TICK_MS * 1.0e6 / MCLK_PERIOD_NS));
   localparam int TRIM_STEP_CYCLES = 10; // Period change of the smallest trim bit

   // Clock source encoding
   typedef enum logic {
      SRC_AUTONOMOUS = 1'b0,
      SRC_BUS_CLOCK = 1'b1
   } clock_source_t;
endpackage

// ===== rtl/osc_tick_if.sv
// Interface between the timer core and its autonomous tick generator
`timescale 1ns/1ns
interface osc_tick_if;
   logic run; // Generator runs while high
   logic [5:0] periodTrim; // Trim of the tick period
   logic tick; // One-cycle tick every autonomous base period

   // Tick generator side
   modport gen (
      input run,
      input periodTrim,
      output tick
   );

   // Timer core side
   modport core (
      output run,
      output periodTrim,
      input tick
   );
endinterface

// ===== rtl/osc_tick_gen.sv
// Trimmed autonomous base tick generator, derived from mclk
`timescale 1ns/1ns
module osc_tick_gen #(
   parameter int BASE_CYCLES = wakeup_timer_pkg::OSC_TICK_CYCLES,
   parameter int STEP_CYCLES = wakeup_timer_pkg::TRIM_STEP_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clkEn,
   osc_tick_if.gen port
);
   localparam int W = wakeup_timer_pkg::OSC_CNT_WIDTH;
   localparam logic [W-1:0] BASE_W = W'(BASE_CYCLES); // Nominal tick length
   localparam logic [W-1:0] STEP_W = W'(STEP_CYCLES); // Weight of trim bit 0
   localparam logic [W-1:0] ONE_W = W'(1);

   logic [W-1:0] cnt_q; // Cycles left in the current tick
   logic [W-1:0] reload; // Trimmed tick length minus one
   logic tick_q; // Registered tick strobe

   // Top trim bit lengthens by 32 steps, lower bits shorten binary weighted
   always_comb begin
      reload = BASE_W - ONE_W;
      if (port.periodTrim[5]) begin
         reload = reload + (STEP_W << 5);
      end
      reload = reload - STEP_W * W'(port.periodTrim[4:0]);
   end

   // Down counter; restarts from the trimmed length so trim acts per tick
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (clkEn) begin
         if (!port.run) begin
            cnt_q <= reload;
            tick_q <= 1'b0;
         end else if (cnt_q == '0) begin
            cnt_q <= reload;
            tick_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q - ONE_W;
            tick_q <= 1'b0;
         end
      end
   end

   assign port.tick = tick_q;
endmodule

// ===== rtl/periodic_wakeup_timer.sv
// Periodic wakeup timer: registers, period counter, pin waveform
//
// Summary of operation
// - Bit 7 picks oscillator or bus clock
// - Source change only while timer stopped
// - Clock mode: pin period twice timer period
// - Pulse mode: one-tick high pulse per timeout
// - Pin driven only with output and run enabled
// - Run enable starts timer; clearing stops it
// - Request raised when flag set and enabled
// - Flag sets at every timeout, stays sticky
// - Writing one clears flag; zero does nothing
// - Clear beats a coincident timeout
// - Six-bit trim field in bits 7..2
// - Top trim bit lengthens, lower bits shorten
// - Trim resets to zero or preset
// - Period is two times (rate plus one) ticks
// - Rate writes ignored while timer runs
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module periodic_wakeup_timer #(
   // Oscillator base tick in mclk cycles; shorten for simulation
   parameter int OSC_TICK_CYCLES = wakeup_timer_pkg::OSC_TICK_CYCLES,
   // Weight of the smallest trim bit in mclk cycles
   parameter int TRIM_STEP_CYCLES = wakeup_timer_pkg::TRIM_STEP_CYCLES,
   // Trim value after reset (zero, or a production preset)
   parameter logic [5:0] TRIM_PRESET = wakeup_timer_pkg::TRIM_RESET
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   output logic timeoutIrq,
   output logic wakeupPin
);
   localparam int CW = wakeup_timer_pkg::COUNT_WIDTH;
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   // Control state
   logic clockSourceSelect_q; // Counting clock source
   logic pinWaveformSelect_q; // Pin shows clock (1) or pulses (0)
   logic pinOutputEnable_q; // Pin routing enable
   logic timerRunEnable_q; // Timer running
   logic timeoutIrqEnable_q; // Request gate
   logic timeoutFlag_q; // Sticky timeout flag
   logic [5:0] periodTrim_q; // Oscillator trim field
   logic [15:0] periodRateValue_q; // Rate value

   // Counter and waveform state
   logic [CW-1:0] periodCount_q; // Ticks elapsed in current period
   logic pinToggle_q; // Square wave, flips at every timeout
   logic pinPulse_q; // One-tick pulse after each timeout

   // Output registers
   logic [7:0] regRdata_q;
   logic timeoutIrq_q;
   logic wakeupPin_q;

   // Decoded accesses
   logic wrControl;
   logic wrTrim;
   logic wrRateHi;
   logic wrRateLo;
   logic clearFlag; // Software clear of the flag
   logic srcTick; // One count step of the selected clock
   logic [CW-1:0] lastCount; // Final count of a period
   logic timeout; // Period elapsed this cycle
   logic [7:0] readMux; // Read value before its register

   // Carrier to the tick generator
   osc_tick_if oscTick ();

   // Autonomous oscillator stand-in, running only while the timer runs
   osc_tick_gen #(
      .BASE_CYCLES(OSC_TICK_CYCLES),
      .STEP_CYCLES(TRIM_STEP_CYCLES)
   ) tickGen (
      .mclk(mclk),
      .reset(reset),
      .clkEn(clkEn),
      .port(oscTick.gen)
   );

   // Generator is only needed on the oscillator source
   assign oscTick.run = timerRunEnable_q &&
      (clockSourceSelect_q == wakeup_timer_pkg::SRC_AUTONOMOUS);
   assign oscTick.periodTrim = periodTrim_q;

   // Address decode of the write strobe
   always_comb begin
      wrControl = regWrite && (regAddr == wakeup_timer_pkg::ADDR_CONTROL);
      wrTrim = regWrite && (regAddr == wakeup_timer_pkg::ADDR_TRIM);
      wrRateHi = regWrite && (regAddr == wakeup_timer_pkg::ADDR_RATE_HI);
      wrRateLo = regWrite && (regAddr == wakeup_timer_pkg::ADDR_RATE_LO);
   end

   // Only a one in the flag position clears it
   assign clearFlag = wrControl && regWdata[wakeup_timer_pkg::BIT_TIMEOUT_FLAG];

   // Bus clock counts every enabled cycle, oscillator counts its ticks
   always_comb begin
      if (clockSourceSelect_q == wakeup_timer_pkg::SRC_BUS_CLOCK) begin
         srcTick = 1'b1;
      end else begin
         srcTick = oscTick.tick;
      end
   end

   // Period spans 2*(rate+1) ticks, so the last count is 2*rate+1
   assign lastCount = {periodRateValue_q, 1'b1};

   // Timeout at the final tick of a period while running
   assign timeout = timerRunEnable_q && srcTick && (periodCount_q == lastCount);

   // Control bits other than the flag
   always_ff @(posedge mclk) begin
      if (reset) begin
         clockSourceSelect_q <= wakeup_timer_pkg::SRC_AUTONOMOUS;
         pinWaveformSelect_q <= 1'b0;
         pinOutputEnable_q <= 1'b0;
         timerRunEnable_q <= 1'b0;
         timeoutIrqEnable_q <= 1'b0;
      end else if (clkEn) begin
         if (wrControl) begin
            // Source may not change under a running or starting timer
            if (!timerRunEnable_q &&
                !regWdata[wakeup_timer_pkg::BIT_TIMER_RUN_ENABLE]) begin
               clockSourceSelect_q <=
                  regWdata[wakeup_timer_pkg::BIT_CLOCK_SOURCE_SELECT];
            end
            pinWaveformSelect_q <= regWdata[wakeup_timer_pkg::BIT_PIN_WAVEFORM_SELECT];
            pinOutputEnable_q <= regWdata[wakeup_timer_pkg::BIT_PIN_OUTPUT_ENABLE];
            timerRunEnable_q <= regWdata[wakeup_timer_pkg::BIT_TIMER_RUN_ENABLE];
            timeoutIrqEnable_q <= regWdata[wakeup_timer_pkg::BIT_TIMEOUT_IRQ_ENABLE];
         end
      end
   end

   // Sticky flag; the clear takes precedence over a same-cycle timeout
   always_ff @(posedge mclk) begin
      if (reset) begin
         timeoutFlag_q <= 1'b0;
      end else if (clkEn) begin
         if (clearFlag) begin
            timeoutFlag_q <= 1'b0;
         end else if (timeout) begin
            timeoutFlag_q <= 1'b1;
         end
      end
   end

   // Trim register, writable at any time
   always_ff @(posedge mclk) begin
      if (reset) begin
         periodTrim_q <= TRIM_PRESET;
      end else if (clkEn) begin
         if (wrTrim) begin
            periodTrim_q <= regWdata[wakeup_timer_pkg::TRIM_MSB:wakeup_timer_pkg::TRIM_LSB];
         end
      end
   end

   // Rate value; locked while running so a period never changes midway
   always_ff @(posedge mclk) begin
      if (reset) begin
         periodRateValue_q <= wakeup_timer_pkg::RATE_RESET;
      end else if (clkEn) begin
         if (wrRateHi && !timerRunEnable_q) begin
            periodRateValue_q[15:8] <= regWdata;
         end
         if (wrRateLo && !timerRunEnable_q) begin
            periodRateValue_q[7:0] <= regWdata;
         end
      end
   end

   // Period counter
   always_ff @(posedge mclk) begin
      if (reset) begin
         periodCount_q <= '0;
      end else if (clkEn) begin
         if (!timerRunEnable_q) begin
            periodCount_q <= '0;
         end else if (timeout) begin
            periodCount_q <= '0;
         end else if (srcTick) begin
            periodCount_q <= periodCount_q + CNT_ONE;
         end
      end
   end

   // Square wave for the clock pin mode, one half period per timeout
   always_ff @(posedge mclk) begin
      if (reset) begin
         pinToggle_q <= 1'b0;
      end else if (clkEn) begin
         if (!timerRunEnable_q) begin
            pinToggle_q <= 1'b0;
         end else if (timeout) begin
            pinToggle_q <= !pinToggle_q;
         end
      end
   end

   // Pulse lasts one tick, which is half the shortest period of two ticks
   always_ff @(posedge mclk) begin
      if (reset) begin
         pinPulse_q <= 1'b0;
      end else if (clkEn) begin
         if (!timerRunEnable_q) begin
            pinPulse_q <= 1'b0;
         end else if (timeout) begin
            pinPulse_q <= 1'b1;
         end else if (srcTick) begin
            pinPulse_q <= 1'b0;
         end
      end
   end

   // Pin output; held low whenever routing or the timer is off
   always_ff @(posedge mclk) begin
      if (reset) begin
         wakeupPin_q <= 1'b0;
      end else if (clkEn) begin
         if (pinOutputEnable_q && timerRunEnable_q) begin
            wakeupPin_q <= pinWaveformSelect_q ? pinToggle_q : pinPulse_q;
         end else begin
            wakeupPin_q <= 1'b0;
         end
      end
   end

   // Interrupt request follows the flag through the enable gate
   always_ff @(posedge mclk) begin
      if (reset) begin
         timeoutIrq_q <= 1'b0;
      end else if (clkEn) begin
         timeoutIrq_q <= timeoutFlag_q && timeoutIrqEnable_q;
      end
   end

   // Read multiplexer; bits 6 and 5 and unmapped addresses read zero
   always_comb begin
      readMux = wakeup_timer_pkg::BYTE_ZERO;
      case (regAddr)
         wakeup_timer_pkg::ADDR_CONTROL: begin
            readMux[wakeup_timer_pkg::BIT_CLOCK_SOURCE_SELECT] = clockSourceSelect_q;
            readMux[wakeup_timer_pkg::BIT_PIN_WAVEFORM_SELECT] = pinWaveformSelect_q;
            readMux[wakeup_timer_pkg::BIT_PIN_OUTPUT_ENABLE] = pinOutputEnable_q;
            readMux[wakeup_timer_pkg::BIT_TIMER_RUN_ENABLE] = timerRunEnable_q;
            readMux[wakeup_timer_pkg::BIT_TIMEOUT_IRQ_ENABLE] = timeoutIrqEnable_q;
            readMux[wakeup_timer_pkg::BIT_TIMEOUT_FLAG] = timeoutFlag_q;
         end
         wakeup_timer_pkg::ADDR_TRIM: begin
            readMux[wakeup_timer_pkg::TRIM_MSB:wakeup_timer_pkg::TRIM_LSB] = periodTrim_q;
         end
         wakeup_timer_pkg::ADDR_RATE_HI: begin
            readMux = periodRateValue_q[15:8];
         end
         wakeup_timer_pkg::ADDR_RATE_LO: begin
            readMux = periodRateValue_q[7:0];
         end
         default: begin
            readMux = wakeup_timer_pkg::BYTE_ZERO; // Unmapped reads zero
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         regRdata_q <= wakeup_timer_pkg::BYTE_ZERO;
      end else if (clkEn) begin
         regRdata_q <= regRead ? readMux : wakeup_timer_pkg::BYTE_ZERO;
      end
   end

   assign regRdata = regRdata_q;
   assign timeoutIrq = timeoutIrq_q;
   assign wakeupPin = wakeupPin_q;
endmodule

// ===== bench/periodic_wakeup_timer_properties.sv
// Port-level assertions for the periodic wakeup timer
`timescale 1ns/1ns
module periodic_wakeup_timer_properties #(
   parameter int OSC_TICK_CYCLES = 1,
   parameter int TRIM_STEP_CYCLES = 1,
   parameter logic [5:0] TRIM_PRESET = 6'h00
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdata,
   input wire logic timeoutIrq,
   input wire logic wakeupPin
);
   logic [7:0] ctrlQ; // Shadow of control bits 7 and 4..1
   logic wrCtrl; // Control write this cycle
   logic wrClr; // Control write with a one in the flag bit
   logic gate; // Pin enable and run enable both set
   logic rdCtrl; // Control read this cycle
   assign wrCtrl = regWrite && regAddr == wakeup_timer_pkg::ADDR_CONTROL;
   assign wrClr = wrCtrl && regWdata[0];
   assign gate = ctrlQ[3] && ctrlQ[2];
   assign rdCtrl = regRead && regAddr == wakeup_timer_pkg::ADDR_CONTROL;
   // Shadow follows writes; the source bit only moves while stopped and not starting
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrlQ <= 8'h00;
      end else if (clkEn && wrCtrl) begin
         ctrlQ[4:1] <= regWdata[4:1];
         if (!ctrlQ[2] && !regWdata[2]) begin
            ctrlQ[7] <= regWdata[7];
         end
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   AST_CTRL_READBACK: assert property ($past(rdCtrl) |-> regRdata[7:1] == $past(ctrlQ[7:1]))
      else $error("control readback differs from written bits");
   AST_TRIM_LOW_ZERO: assert property ($past(regRead)
      && $past(regAddr) == wakeup_timer_pkg::ADDR_TRIM |-> regRdata[1:0] == 2'b00)
      else $error("trim low bits not zero");
   AST_IRQ_MATCHES_FLAG: assert property ($past(rdCtrl) |-> timeoutIrq == (regRdata[1] & regRdata[0]))
      else $error("request disagrees with flag and enable");
   AST_IRQ_MASKED: assert property (!$past(ctrlQ[1]) |-> !timeoutIrq)
      else $error("request raised while disabled");
   AST_FLAG_STICKY: assert property ($fell(timeoutIrq) && $past(ctrlQ[1]) |-> $past(wrClr, 2))
      else $error("flag dropped without a clear");
   AST_PIN_GATED: assert property (!gate && !$past(gate) && !$past(gate, 2) |-> !wakeupPin)
      else $error("pin driven while not enabled");
   AST_PULSE_WIDTH: assert property ($rose(wakeupPin) && !ctrlQ[4] && !$past(ctrlQ[4], 2)
      && ctrlQ[7] && $past(ctrlQ[7], 2) |=> !wakeupPin)
      else $error("bus clock pulse longer than one cycle");
   AST_TIMEOUT_NEEDS_RUN: assert property ($rose(timeoutIrq) && $past(ctrlQ[1], 2)
      |-> $past(ctrlQ[2], 2))
      else $error("timeout while stopped");
endmodule

bind periodic_wakeup_timer periodic_wakeup_timer_properties #(.OSC_TICK_CYCLES(OSC_TICK_CYCLES),
   .TRIM_STEP_CYCLES(TRIM_STEP_CYCLES), .TRIM_PRESET(TRIM_PRESET)) props (.mclk(mclk),
   .reset(reset), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
   .regRead(regRead), .regRdata(regRdata), .timeoutIrq(timeoutIrq), .wakeupPin(wakeupPin));

// ===== bench/tb.sv
// Self-checking testbench for the periodic wakeup timer
`timescale 1ns/1ns
module tb;
   localparam int TICK = 40; // Shortened oscillator tick, above 31 trim steps
   localparam logic [5:0] PRESET = 6'h15; // Nonzero preset shows the reset path
   localparam logic [15:0] CT = wakeup_timer_pkg::ADDR_CONTROL;
   localparam logic [15:0] TR = wakeup_timer_pkg::ADDR_TRIM;
   localparam logic [15:0] RL = wakeup_timer_pkg::ADDR_RATE_LO;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic clkEn = 1'b1; // Held high throughout
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdata;
   logic timeoutIrq;
   logic wakeupPin;
   int miscompares = 0;
   int compares = 0;
   int n, w; // Measured cycle counts
   logic [5:0] trims [3] = '{6'h00, 6'h20, 6'h10}; // Neutral, lengthen, shorten
   int periods [3] = '{2 * TICK, 2 * (TICK + 32), 2 * (TICK - 16)};
   // Free-running 100 MHz clock
   always #5 mclk = ~mclk;
   periodic_wakeup_timer #(.OSC_TICK_CYCLES(TICK), .TRIM_STEP_CYCLES(1), .TRIM_PRESET(PRESET)) uut (
      .mclk(mclk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .timeoutIrq(timeoutIrq),
      .wakeupPin(wakeupPin));
   // Counts a comparison, reports a difference
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle write, then a gap so strobes never collide
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
      @(posedge mclk);
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 check(what, exp, regRdata);
      @(posedge mclk);
   endtask
   // Edges until pin or request reaches a level; 400 means never
   task automatic waitSig(input bit pin, input logic lvl, output int k);
      k = 0;
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while ((pin ? wakeupPin : timeoutIrq) !== lvl && k < 400);
   endtask
   // Reset values, including the trim preset and an unmapped byte
   task automatic test_reset();
      rd(CT, 8'h00, "control");
      rd(TR, {PRESET, 2'b00}, "trim");
      rd(RL, 8'h00, "rate low");
      rd(16'h02f6, 8'h00, "unmapped");
   endtask
   // Source bit moves only while stopped and not in a starting write
   task automatic test_source();
      wr(CT, 8'h80);
      rd(CT, 8'h80, "source bus");
      wr(CT, 8'h7e);
      rd(CT, 8'h9e, "source held on start");
      wr(CT, 8'h00);
      rd(CT, 8'h81, "source held while running");
      wr(TR, 8'hff);
      rd(TR, 8'hfc, "trim field");
   endtask
   // Clock waveform on bus clock; rate locked while running
   task automatic test_clock_pin();
      wr(RL, 8'h03);
      wr(CT, 8'h9c);
      waitSig(1, 1, n);
      waitSig(1, 0, n);
      check("clock half period", 8, n);
      wr(RL, 8'h07);
      waitSig(1, 1, n);
      waitSig(1, 0, n);
      check("period after locked write", 8, n);
      rd(RL, 8'h03, "rate locked");
      wr(CT, 8'h8c);
      waitSig(1, 1, n);
      waitSig(1, 0, w);
      waitSig(1, 1, n);
      check("pulse width", 1, w);
      check("pulse spacing", 8, w + n);
      wr(CT, 8'h84);
      waitSig(1, 1, n);
      check("pin gated", 400, n);
      wr(CT, 8'h80);
   endtask
   // Flag setting, masking, write-one clear and clear against a timeout
   task automatic test_flag();
      wr(RL, 8'h14);
      // Start with a write-one clear, so the stale flag from earlier runs is gone
      wr(CT, 8'h87);
      waitSig(0, 1, n);
      check("first request", 1, n < 400);
      // Next timeout cycle falls 41 edges after the request was seen
      repeat (40) @(posedge mclk);
      wr(CT, 8'h87);
      rd(CT, 8'h86, "clear beats timeout");
      wr(CT, 8'h84);
      waitSig(0, 1, n);
      check("masked request", 400, n);
      rd(CT, 8'h85, "flag sticky");
      wr(CT, 8'h86);
      waitSig(0, 1, n);
      check("request on enable", 1, n);
      wr(CT, 8'h80);
      wr(CT, 8'h01);
      rd(CT, 8'h00, "flag cleared");
   endtask
   // Oscillator source: trim moves the base tick in binary steps
   task automatic test_osc();
      wr(RL, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(TR, {trims[i], 2'b00});
         wr(CT, 8'h0c);
         waitSig(1, 1, n);
         waitSig(1, 0, w);
         waitSig(1, 1, n);
         check("trimmed period", periods[i], w + n);
         check("trimmed pulse", periods[i] / 2, w);
         wr(CT, 8'h00);
      end
   endtask
   // Verdict and end of run
   task automatic conclude();
      if (miscompares == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hang guard, well past the expected few thousand cycles
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      test_reset();
      test_source();
      test_clock_pin();
      test_flag();
      test_osc();
      conclude();
   end
endmodule
